/* design/hbcr_top.sv */
// Behaviour
// - overvoltage retry bit 1 gives retry, 0 latches the fault reaction
// - same bit also picks retry or latch for undervoltage on external rail
// - active open-load retry bit 1 gives retry, else latched
// - coast-extension bit enables extra coast states in PWM mode
// - load-type field sits in bits 6:5 of load_trip_config
// - current-trip level field sits in bits 2:0 of load_trip_config
// - off time codes 0..3 give 20, 30, 40, 50 us
// - slew-rate field sits in bits 4:2 of timing_mode_config
// - mode field sits in bits 1:0 of timing_mode_config
// - overcurrent filter codes give 6, 3, 1.5 us and minimum 0.2 us
// - threshold codes give 100, 50, 75, 75 percent
// - unlocked: shutoff is pin OR bit when select 0, AND when 1
// - unlocked: input one is pin OR bit when select 0, AND when 1
// - unlocked: input two is pin OR bit when select 0, AND when 1
// - load_trip_config at 0x0b, resets to 0x00
// - timing_mode_config at 0x0c, resets to 0x40
// - overcurrent_combine_config at 0x0d, resets to 0x04
// - register input bits act only while input control is unlocked
// - input lock field: 01 locks, 10 unlocks, others ignored; locked default
// - config lock field: 01 unlocks, 10 locks, others ignored; unlocked
`timescale 1ns/10ps
`default_nettype none
module hbcr_top
  import hbcr_pkg::*;
#(
  parameter int CNT_W = 11
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port from serial interface
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  // input pins
  input wire logic i_drive_shutoff_pin,
  input wire logic i_enable_input_one_pin,
  input wire logic i_phase_input_two_pin,
  // fault detectors
  input wire logic i_supply_overvoltage,
  input wire logic i_supply_undervoltage,
  input wire logic i_active_open_load,
  input wire logic i_ext_logic_rail,
  // effective inputs
  output logic o_drive_shutoff,
  output logic o_input_one,
  output logic o_input_two,
  // configuration outputs
  output logic o_coast_extend,
  output logic [1:0] o_load_type_field,
  output logic [2:0] o_current_trip_level,
  output logic [2:0] o_slew_rate_field,
  output logic [1:0] o_bridge_mode,
  output logic [CNT_W-1:0] o_off_time_cycles,
  output logic [CNT_W-1:0] o_oc_filter_cycles,
  output logic [6:0] o_oc_threshold_pct,
  // fault reactions
  output logic o_ov_disable,
  output logic o_uv_disable,
  output logic o_ola_disable,
  output logic o_fault_latched
);
  logic [7:0] fault_cfg_r;
  logic [7:0] load_trip_r;
  logic [7:0] timing_mode_r;
  logic [7:0] oc_combine_r;
  logic [7:0] inreg_r;
  logic in_unlocked_r;
  logic cfg_locked_r;
  logic [7:0] rdata_nxt;
  logic clear_pulse;
  logic ov_retry;
  logic active_openload_retry_sel;
  logic uv_retry;
  logic ov_lat;
  logic uv_lat;
  logic ola_lat;
  logic cfg_wr_ok;
  logic cmd_wr;
  logic [1:0] inlock_code;
  logic [1:0] reglock_code;
  logic shutoff_mix;
  logic input_one_mix;
  logic input_two_mix;

  function automatic logic combine(input logic pin, input logic bitv,
                                   input logic sel);
    combine = sel ? (pin & bitv) : (pin | bitv);
  endfunction

  function automatic logic [7:0] wr_field(input logic [7:0] wd,
                                          input logic [7:0] mask);
    wr_field = wd & mask;
  endfunction

  assign cfg_wr_ok = i_wr_en && !cfg_locked_r;
  assign cmd_wr = i_wr_en && (i_addr == HBCR_CMD_ADDR);
  assign clear_pulse = cmd_wr && i_wdata[HBCR_CLR_FLT_BIT];
  assign inlock_code = i_wdata[HBCR_INLOCK_LSB +: 2];
  assign reglock_code = i_wdata[HBCR_REGLOCK_LSB +: 2];

  // pin and register mixes; the selects only matter once unlocked
  assign shutoff_mix = combine(i_drive_shutoff_pin,
                               inreg_r[HBCR_SHUTOFF_REG_BIT],
                               oc_combine_r[HBCR_SHUTOFF_SEL_BIT]);
  assign input_one_mix = combine(i_enable_input_one_pin,
                                 inreg_r[HBCR_IN1_REG_BIT],
                                 oc_combine_r[HBCR_IN1_SEL_BIT]);
  assign input_two_mix = combine(i_phase_input_two_pin,
                                 inreg_r[HBCR_IN2_REG_BIT],
                                 oc_combine_r[HBCR_IN2_SEL_BIT]);

  // lock fields, only the defined codes act
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      in_unlocked_r <= 1'b0;
      cfg_locked_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (inlock_code == HBCR_CODE_01)
        in_unlocked_r <= 1'b0;
      else if (inlock_code == HBCR_CODE_10)
        in_unlocked_r <= 1'b1;
      if (reglock_code == HBCR_CODE_01)
        cfg_locked_r <= 1'b0;
      else if (reglock_code == HBCR_CODE_10)
        cfg_locked_r <= 1'b1;
    end
  end

  // configuration registers, guarded by the config lock
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      fault_cfg_r <= HBCR_FAULT_CFG_RST;
      load_trip_r <= HBCR_LOAD_TRIP_RST;
      timing_mode_r <= HBCR_TIMING_MODE_RST;
      oc_combine_r <= HBCR_OC_COMBINE_RST;
    end
    else if (cfg_wr_ok)
    begin
      if (i_addr == HBCR_FAULT_CFG_ADDR)
        fault_cfg_r <= wr_field(i_wdata, HBCR_FAULT_CFG_MASK);
      if (i_addr == HBCR_LOAD_TRIP_ADDR)
        load_trip_r <= wr_field(i_wdata, HBCR_LOAD_TRIP_MASK);
      if (i_addr == HBCR_TIMING_MODE_ADDR)
        timing_mode_r <= wr_field(i_wdata, HBCR_TIMING_MODE_MASK);
      if (i_addr == HBCR_OC_COMBINE_ADDR)
        oc_combine_r <= wr_field(i_wdata, HBCR_OC_COMBINE_MASK);
    end
  end

  // input substitute register, written regardless of the config lock
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      inreg_r <= HBCR_INREG_RST;
    else if (i_wr_en && i_addr == HBCR_INREG_ADDR)
      inreg_r <= wr_field(i_wdata, HBCR_INREG_MASK);
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (i_addr)
      HBCR_CMD_ADDR:
        rdata_nxt = {3'h0, in_unlocked_r ? HBCR_CODE_10 : HBCR_CODE_01,
                     1'b0, cfg_locked_r ? HBCR_CODE_10 : HBCR_CODE_01};
      HBCR_INREG_ADDR: rdata_nxt = inreg_r;
      HBCR_FAULT_CFG_ADDR: rdata_nxt = fault_cfg_r;
      HBCR_LOAD_TRIP_ADDR: rdata_nxt = load_trip_r;
      HBCR_TIMING_MODE_ADDR: rdata_nxt = timing_mode_r;
      HBCR_OC_COMBINE_ADDR: rdata_nxt = oc_combine_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en)
        o_rdata <= rdata_nxt;
    end
  end

  // effective inputs; locked means pins alone drive the bridge
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_drive_shutoff <= 1'b0;
      o_input_one <= 1'b0;
      o_input_two <= 1'b0;
    end
    else if (in_unlocked_r)
    begin
      o_drive_shutoff <= shutoff_mix;
      o_input_one <= input_one_mix;
      o_input_two <= input_two_mix;
    end
    else
    begin
      o_drive_shutoff <= i_drive_shutoff_pin;
      o_input_one <= i_enable_input_one_pin;
      o_input_two <= i_phase_input_two_pin;
    end
  end

  // field decode
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_off_time_cycles <= '0;
      o_oc_filter_cycles <= '0;
      o_oc_threshold_pct <= HBCR_THR_PCT_FULL;
    end
    else
    begin
      unique case (timing_mode_r[HBCR_REGULATION_OFF_TIME_LSB +: 2])
        2'h0: o_off_time_cycles <= CNT_W'(HBCR_REGULATION_OFF_TIME_CYC_0);
        2'h1: o_off_time_cycles <= CNT_W'(HBCR_REGULATION_OFF_TIME_CYC_1);
        2'h2: o_off_time_cycles <= CNT_W'(HBCR_REGULATION_OFF_TIME_CYC_2);
        2'h3: o_off_time_cycles <= CNT_W'(HBCR_REGULATION_OFF_TIME_CYC_3);
      endcase
      unique case (oc_combine_r[HBCR_OCP_TIME_LSB +: 2])
        2'h0: o_oc_filter_cycles <= CNT_W'(HBCR_OCP_CYC_0);
        2'h1: o_oc_filter_cycles <= CNT_W'(HBCR_OCP_CYC_1);
        2'h2: o_oc_filter_cycles <= CNT_W'(HBCR_OCP_CYC_2);
        2'h3: o_oc_filter_cycles <= CNT_W'(HBCR_OCP_CYC_3);
      endcase
      unique case (oc_combine_r[HBCR_OCP_THR_LSB +: 2])
        2'h0: o_oc_threshold_pct <= HBCR_THR_PCT_FULL;
        2'h1: o_oc_threshold_pct <= HBCR_THR_PCT_HALF;
        2'h2, 2'h3: o_oc_threshold_pct <= HBCR_THR_PCT_3Q;
      endcase
    end
  end

  // plain field views straight from the registers
  assign o_coast_extend = load_trip_r[HBCR_COAST_EXT_BIT];
  assign o_load_type_field = load_trip_r[HBCR_LOAD_TYPE_LSB +: 2];
  assign o_current_trip_level = load_trip_r[HBCR_CURRENT_TRIP_REGULATION_LSB +: 3];
  assign o_slew_rate_field = timing_mode_r[HBCR_SLEW_LSB +: 3];
  assign o_bridge_mode = timing_mode_r[HBCR_MODE_LSB +: 2];

  // retry selects; undervoltage follows overvoltage only on external rail
  assign ov_retry = fault_cfg_r[HBCR_OV_RETRY_BIT];
  assign active_openload_retry_sel = fault_cfg_r[HBCR_ACTIVE_OPENLOAD_RETRY_SEL_BIT];
  assign uv_retry = i_ext_logic_rail ? ov_retry : 1'b1;

  hbcr_fault_react u_ov
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_fault(i_supply_overvoltage),
    .i_retry_sel(ov_retry),
    .i_clear(clear_pulse),
    .o_disable(o_ov_disable),
    .o_latched(ov_lat)
  );

  hbcr_fault_react u_uv
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_fault(i_supply_undervoltage),
    .i_retry_sel(uv_retry),
    .i_clear(clear_pulse),
    .o_disable(o_uv_disable),
    .o_latched(uv_lat)
  );

  hbcr_fault_react u_ola
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_fault(i_active_open_load),
    .i_retry_sel(active_openload_retry_sel),
    .i_clear(clear_pulse),
    .o_disable(o_ola_disable),
    .o_latched(ola_lat)
  );

  assign o_fault_latched = ov_lat | uv_lat | ola_lat;
endmodule
`default_nettype wire

/* design/hbcr_pkg.sv */
package hbcr_pkg;
  // register offsets
  localparam logic [7:0] HBCR_CMD_ADDR = 8'h08;
  localparam logic [7:0] HBCR_INREG_ADDR = 8'h09;
  localparam logic [7:0] HBCR_FAULT_CFG_ADDR = 8'h0a;
  localparam logic [7:0] HBCR_LOAD_TRIP_ADDR = 8'h0b;
  localparam logic [7:0] HBCR_TIMING_MODE_ADDR = 8'h0c;
  localparam logic [7:0] HBCR_OC_COMBINE_ADDR = 8'h0d;
  // reset values
  localparam logic [7:0] HBCR_FAULT_CFG_RST = 8'h10;
  localparam logic [7:0] HBCR_LOAD_TRIP_RST = 8'h00;
  localparam logic [7:0] HBCR_TIMING_MODE_RST = 8'h40;
  localparam logic [7:0] HBCR_OC_COMBINE_RST = 8'h04;
  localparam logic [7:0] HBCR_INREG_RST = 8'h0c;
  // writable masks
  localparam logic [7:0] HBCR_FAULT_CFG_MASK = 8'hff;
  localparam logic [7:0] HBCR_LOAD_TRIP_MASK = 8'he7;
  localparam logic [7:0] HBCR_TIMING_MODE_MASK = 8'hdf;
  localparam logic [7:0] HBCR_OC_COMBINE_MASK = 8'hdf;
  localparam logic [7:0] HBCR_INREG_MASK = 8'h0f;
  // field positions
  localparam int HBCR_OV_RETRY_BIT = 1;
  localparam int HBCR_ACTIVE_OPENLOAD_RETRY_SEL_BIT = 0;
  localparam int HBCR_COAST_EXT_BIT = 7;
  localparam int HBCR_LOAD_TYPE_LSB = 5;
  localparam int HBCR_CURRENT_TRIP_REGULATION_LSB = 0;
  localparam int HBCR_REGULATION_OFF_TIME_LSB = 6;
  localparam int HBCR_SLEW_LSB = 2;
  localparam int HBCR_MODE_LSB = 0;
  localparam int HBCR_OCP_TIME_LSB = 6;
  localparam int HBCR_OCP_THR_LSB = 3;
  localparam int HBCR_SHUTOFF_SEL_BIT = 2;
  localparam int HBCR_IN1_SEL_BIT = 1;
  localparam int HBCR_IN2_SEL_BIT = 0;
  localparam int HBCR_INLOCK_LSB = 3;
  localparam int HBCR_REGLOCK_LSB = 0;
  localparam int HBCR_CLR_FLT_BIT = 7;
  localparam int HBCR_SHUTOFF_REG_BIT = 3;
  localparam int HBCR_IN1_REG_BIT = 1;
  localparam int HBCR_IN2_REG_BIT = 0;
  // lock codes
  localparam logic [1:0] HBCR_CODE_01 = 2'h1;
  localparam logic [1:0] HBCR_CODE_10 = 2'h2;
  // timing, clock 25 MHz
  localparam int HBCR_CLK_KHZ = 25000;
  localparam int HBCR_REGULATION_OFF_TIME_US_0 = 20;
  localparam int HBCR_REGULATION_OFF_TIME_US_1 = 30;
  localparam int HBCR_REGULATION_OFF_TIME_US_2 = 40;
  localparam int HBCR_REGULATION_OFF_TIME_US_3 = 50;
  localparam int HBCR_REGULATION_OFF_TIME_CYC_0 = HBCR_REGULATION_OFF_TIME_US_0 * HBCR_CLK_KHZ / 1000;
  localparam int HBCR_REGULATION_OFF_TIME_CYC_1 = HBCR_REGULATION_OFF_TIME_US_1 * HBCR_CLK_KHZ / 1000;
  localparam int HBCR_REGULATION_OFF_TIME_CYC_2 = HBCR_REGULATION_OFF_TIME_US_2 * HBCR_CLK_KHZ / 1000;
  localparam int HBCR_REGULATION_OFF_TIME_CYC_3 = HBCR_REGULATION_OFF_TIME_US_3 * HBCR_CLK_KHZ / 1000;
  // deglitch in ns
  localparam int HBCR_OCP_NS_0 = 6000;
  localparam int HBCR_OCP_NS_1 = 3000;
  localparam int HBCR_OCP_NS_2 = 1500;
  localparam int HBCR_OCP_NS_3 = 200;
  localparam int HBCR_OCP_CYC_0 = (HBCR_OCP_NS_0 * HBCR_CLK_KHZ) / 1000000;
  localparam int HBCR_OCP_CYC_1 = (HBCR_OCP_NS_1 * HBCR_CLK_KHZ) / 1000000;
  localparam int HBCR_OCP_CYC_2 = (HBCR_OCP_NS_2 * HBCR_CLK_KHZ) / 1000000;
  localparam int HBCR_OCP_CYC_3 = (HBCR_OCP_NS_3 * HBCR_CLK_KHZ) / 1000000;
  // threshold percent
  localparam logic [6:0] HBCR_THR_PCT_FULL = 7'd100;
  localparam logic [6:0] HBCR_THR_PCT_HALF = 7'd50;
  localparam logic [6:0] HBCR_THR_PCT_3Q = 7'd75;
endpackage

/* design/hbcr_fault_react.sv */
`timescale 1ns/10ps
`default_nettype none
module hbcr_fault_react
  import hbcr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // fault condition and control
  input wire logic i_fault,
  input wire logic i_retry_sel,
  input wire logic i_clear,
  // reaction
  output logic o_disable,
  output logic o_latched
);
  logic latched_r;

  // latched stays until clear; a latching fault in the clear cycle wins
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      latched_r <= 1'b0;
    else if (i_fault && !i_retry_sel)
      latched_r <= 1'b1;
    else if (i_clear)
      latched_r <= 1'b0;
  end

  assign o_latched = latched_r;
  assign o_disable = latched_r || i_fault;
endmodule
`default_nettype wire

/* bench/hbcr_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module hbcr_monitor
  import hbcr_pkg::*;
#(
  parameter int CNT_W = 11
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_rd_valid,
  // pins and faults
  input wire logic i_enable_input_one_pin,
  input wire logic i_supply_overvoltage,
  input wire logic i_supply_undervoltage,
  input wire logic i_active_open_load,
  input wire logic i_ext_logic_rail,
  // outputs watched
  input wire logic o_input_one,
  input wire logic [CNT_W-1:0] o_off_time_cycles,
  input wire logic [CNT_W-1:0] o_oc_filter_cycles,
  input wire logic [6:0] o_oc_threshold_pct,
  input wire logic o_ov_disable,
  input wire logic o_uv_disable,
  input wire logic o_ola_disable,
  input wire logic o_fault_latched
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic in_lock_r;
  // shadow of the input lock, so pin pass-through can be judged
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      in_lock_r <= 1'b1;
    else if (i_wr_en && i_addr == HBCR_CMD_ADDR && i_wdata[4:3] == 2'h1)
      in_lock_r <= 1'b1;
    else if (i_wr_en && i_addr == HBCR_CMD_ADDR && i_wdata[4:3] == 2'h2)
      in_lock_r <= 1'b0;
  end
  property p_rd_valid;
    o_rd_valid == $past(i_rd_en);
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read valid not one cycle after read");
  property p_regulation_off_time;
    !$past(i_rst) && !$past(i_rst, 2) |->
      o_off_time_cycles inside {11'd500, 11'd750, 11'd1000, 11'd1250};
  endproperty
  a_regulation_off_time: assert property (p_regulation_off_time)
    else $error("off time count out of set");
  property p_ocf;
    !$past(i_rst) && !$past(i_rst, 2) |->
      o_oc_filter_cycles inside {11'd150, 11'd75, 11'd37, 11'd5};
  endproperty
  a_ocf: assert property (p_ocf)
    else $error("filter count out of set");
  property p_thr;
    !$past(i_rst) && !$past(i_rst, 2) |->
      o_oc_threshold_pct inside {7'd100, 7'd50, 7'd75};
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold out of set");
  property p_ov;
    i_supply_overvoltage |-> o_ov_disable;
  endproperty
  a_ov: assert property (p_ov)
    else $error("overvoltage did not disable");
  property p_ola;
    i_active_open_load |-> o_ola_disable;
  endproperty
  a_ola: assert property (p_ola)
    else $error("open load did not disable");
  property p_uv_int;
    !i_ext_logic_rail && !i_supply_undervoltage |-> !o_uv_disable;
  endproperty
  a_uv_int: assert property (p_uv_int)
    else $error("undervoltage held without external rail");
  property p_latch;
    o_ov_disable && !i_supply_overvoltage |-> ##[0:1] o_fault_latched;
  endproperty
  a_latch: assert property (p_latch)
    else $error("held disable without latched flag");
  property p_resume;
    !o_fault_latched |-> o_ov_disable == i_supply_overvoltage;
  endproperty
  a_resume: assert property (p_resume)
    else $error("retry disable not following fault");
  property p_locked;
    $past(in_lock_r) && !$past(i_rst) |->
      o_input_one == $past(i_enable_input_one_pin);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked input one not following pin");
endmodule
bind hbcr_top hbcr_monitor #(.CNT_W(CNT_W)) i_monitor (.*);
`default_nettype wire

/* bench/hbcr_host.sv */
`timescale 1ns/10ps
`default_nettype none
module hbcr_host
(
  // clock
  input wire logic i_ref_clk,
  // answer from the block
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_valid,
  // requests
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // released lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    // read valid stands only one cycle: catch it before releasing
    @(negedge i_ref_clk);
    d = i_rd_valid ? i_rdata : 8'hxx;
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask
endmodule
`default_nettype wire

/* bench/hbcr_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module hbcr_top_tb;
  logic clk = 1'b0, rst = 1'b1, wr_en, rd_en, rd_valid, coast;
  logic [7:0] addr, wdata, rdata;
  logic shut = 1'b0, in1 = 1'b0, in2 = 1'b0, eff_off, eff_1, eff_2;
  logic ov = 1'b0, uv = 1'b0, active_open_load = 1'b0, ext = 1'b0;
  logic ovd, uvd, olad, flt;
  logic [1:0] ltype, mode;
  logic [2:0] current_trip_regulation, slew;
  logic [10:0] regulation_off_time, ocf;
  logic [6:0] thr;
  int failures = 0, check_count = 0;
  int ocf_tab[4] = '{150, 75, 37, 5};
  int thr_tab[4] = '{100, 50, 75, 75};
  always #20 clk = ~clk;
  hbcr_host i_host (.i_ref_clk(clk), .i_rdata(rdata),
    .i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));
  hbcr_top #(.CNT_W(11)) i_dut (.i_ref_clk(clk), .i_rst(rst),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_drive_shutoff_pin(shut), .i_enable_input_one_pin(in1),
    .i_phase_input_two_pin(in2), .i_supply_overvoltage(ov),
    .i_supply_undervoltage(uv), .i_active_open_load(active_open_load),
    .i_ext_logic_rail(ext), .o_drive_shutoff(eff_off),
    .o_input_one(eff_1), .o_input_two(eff_2), .o_coast_extend(coast),
    .o_load_type_field(ltype), .o_current_trip_level(current_trip_regulation),
    .o_slew_rate_field(slew), .o_bridge_mode(mode),
    .o_off_time_cycles(regulation_off_time), .o_oc_filter_cycles(ocf),
    .o_oc_threshold_pct(thr), .o_ov_disable(ovd), .o_uv_disable(uvd),
    .o_ola_disable(olad), .o_fault_latched(flt));
  task automatic chk(input string n, input logic [10:0] e,
    input logic [10:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("rdata", {3'h0, e}, {3'h0, d});
  endtask
  task automatic pins(input logic p);
    @(negedge clk);
    {shut, in1, in2} = {3{p}};
    repeat (2) @(negedge clk);
  endtask
  task automatic fault_pulse;
    @(negedge clk);
    {ov, uv, active_open_load} = 3'h7;
    repeat (2) @(negedge clk);
    {ov, uv, active_open_load} = 3'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    end_of_test();
  end
  initial
  begin
    logic e;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rchk(8'h0b, 8'h00);
    rchk(8'h0c, 8'h40);
    rchk(8'h0d, 8'h04);
    rchk(8'h20, 8'h00);
    rchk(8'h08, 8'h09);
    rchk(8'h09, 8'h0c);
    rchk(8'h0a, 8'h10);
    chk("regulation_off_time", 11'd750, regulation_off_time);
    $display("test reset done");
    i_host.wr(8'h0b, 8'hb2);
    rchk(8'h0b, 8'ha2);
    chk("fields", 11'h02a, {5'h0, coast, ltype, current_trip_regulation});
    for (int c = 0; c < 4; c++)
    begin
      i_host.wr(8'h0c, {c[1:0], 6'h3d});
      i_host.wr(8'h0d, {c[1:0], 1'b1, c[1:0], 3'h0});
      rchk(8'h0c, {c[1:0], 6'h1d});
      chk("regulation_off_time", 11'((20 + 10 * c) * 25), regulation_off_time);
      chk("ocf", 11'(ocf_tab[c]), ocf);
      chk("thr", 11'(thr_tab[c]), {4'h0, thr});
      chk("slew_mode", 11'h01d, {6'h0, slew, mode});
    end
    $display("test fields done");
    i_host.wr(8'h08, 8'h10);
    for (int k = 0; k < 8; k++)
    begin
      i_host.wr(8'h0d, {5'h0, {3{k[2]}}});
      i_host.wr(8'h09, k[0] ? 8'h0b : 8'h00);
      pins(k[1]);
      e = k[2] ? (k[1] & k[0]) : (k[1] | k[0]);
      chk("combine", {8'h0, {3{e}}}, {8'h0, eff_off, eff_1, eff_2});
    end
    i_host.wr(8'h0d, 8'h00);
    i_host.wr(8'h08, 8'h18);
    pins(1'b0);
    chk("unlocked", 11'h007, {8'h0, eff_off, eff_1, eff_2});
    i_host.wr(8'h08, 8'h08);
    pins(1'b0);
    chk("locked", 11'h000, {8'h0, eff_off, eff_1, eff_2});
    $display("test combine done");
    i_host.wr(8'h08, 8'h02);
    rchk(8'h08, 8'h0a);
    i_host.wr(8'h0b, 8'h00);
    rchk(8'h0b, 8'ha2);
    i_host.wr(8'h08, 8'h03);
    i_host.wr(8'h0b, 8'h00);
    rchk(8'h0b, 8'ha2);
    i_host.wr(8'h08, 8'h01);
    i_host.wr(8'h0b, 8'h00);
    rchk(8'h0b, 8'h00);
    $display("test config lock done");
    ext = 1'b1;
    i_host.wr(8'h0a, 8'h10);
    fault_pulse();
    chk("latched", 11'h00f, {7'h0, ovd, uvd, olad, flt});
    i_host.wr(8'h08, 8'h80);
    pins(1'b0);
    chk("cleared", 11'h000, {7'h0, ovd, uvd, olad, flt});
    i_host.wr(8'h0a, 8'h13);
    fault_pulse();
    chk("retry", 11'h000, {7'h0, ovd, uvd, olad, flt});
    ext = 1'b0;
    $display("test faults done");
    end_of_test();
  end
endmodule
`default_nettype wire
